// [bench/async_timer_sync_and_compare_output_test.sv]
// self-checking bench for the asynchronous timer block
// assumes the oscillator model drives the oscillator input pin
`timescale 1ns/1ps
`define CHK(g, e) \
   begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module async_timer_sync_and_compare_output_test;
   logic sys_clk_i, rst_b_i, clk_en_i, wr_i, rd_i, sleep_save_i, sleep_deep_i;
   logic [7:0] addr_i, wdata_i, q;
   wire [7:0] rdata_o;
   wire osc, osc_run_o, osc_external_o, port_c_detach_o, compare_a_output_o;
   wire oca_override_o, wake_o, cpu_halt_o, irq_req_o;
   int err_count = 0;
   int n_tests = 0;
   int k;
   logic [7:0] offs [10] = '{8'ha3, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb6, 8'hb7,
      8'hb8, 8'h00};
   logic [1:0] mode [5] = '{2'b11, 2'b00, 2'b10, 2'b01, 2'b01};
   logic oc_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

   atsc_timer dut (.osc_in_pin_i(osc), .*);
   atsc_osc_model osc_m (.run_i(osc_run_o), .osc_o(osc));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic test_done();
      if (err_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // one bus cycle; q picks up the answer to the previous read
   task automatic bus(input logic w, r, input logic [7:0] a, d);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= d;
      @(negedge sys_clk_i);
      q = rdata_o;
      @(posedge sys_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, 8'h00);
   endtask

   task automatic rdc(input logic [7:0] a, e, m);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      `CHK(q & m, e)
   endtask

   // bounded poll of a register field
   task automatic wait_val(input logic [7:0] a, m, e);
      int i;
      for (i = 0; i < 100; i++)
      begin
         bus(1'b0, 1'b1, a, 8'h00);
         bus(1'b0, 1'b0, a, 8'h00);
         if ((q & m) === e)
            break;
      end
      if (i == 100)
      begin
         err_count++;
         $display("ERROR %0t poll got %h exp %h", $time, q & m, e);
         test_done();
      end
   endtask

   initial
   begin
      rst_b_i = 1'b0;
      clk_en_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      sleep_save_i = 1'b0;
      sleep_deep_i = 1'b0;
      repeat (5) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      foreach (offs[j])
         rdc(offs[j], 8'h00, 8'hff);
      `CHK({osc_run_o, port_c_detach_o, oca_override_o}, 3'h0)
      // writes to separate holding registers, a status read between them
      bus(1'b1, 1'b0, 8'hb3, 8'h5a);
      bus(1'b0, 1'b1, 8'hb6, 8'h00);
      bus(1'b1, 1'b0, 8'hb2, 8'h03);
      `CHK(q[3], 1'b1)
      bus(1'b0, 1'b1, 8'hb6, 8'h00);
      bus(1'b0, 1'b0, 8'hb6, 8'h00);
      `CHK(q[4:3], 2'b10)
      wait_val(8'hb6, 8'h1f, 8'h00);
      rdc(8'hb3, 8'h5a, 8'hff);
      rdc(8'hb2, 8'h03, 8'hff);
      // forced match under every output mode
      foreach (mode[j])
      begin
         wr(8'hb0, {mode[j], 6'h00});
         wait_val(8'hb6, 8'h1f, 8'h00);
         wr(8'hb1, 8'h80);
         @(negedge sys_clk_i);
         `CHK(compare_a_output_o, oc_exp[j])
         `CHK(oca_override_o, |mode[j])
         @(posedge sys_clk_i);
      end
      rdc(8'hb7, 8'h00, 8'hff);
      rdc(8'hb1, 8'h00, 8'hff);
      // force strobe ignored in fast pwm
      wr(8'hb0, 8'hc3);
      wait_val(8'hb6, 8'h1f, 8'h00);
      wr(8'hb1, 8'h80);
      @(negedge sys_clk_i);
      `CHK(compare_a_output_o, 1'b0)
      @(posedge sys_clk_i);
      wr(8'hb0, 8'h40);
      // real match, flag and interrupt
      wr(8'hb3, 8'h10);
      wr(8'hb8, 8'h02);
      wr(8'hb1, 8'h01);
      wait_val(8'hb7, 8'h02, 8'h02);
      @(negedge sys_clk_i);
      `CHK(irq_req_o, 1'b1)
      @(posedge sys_clk_i);
      wr(8'hb7, 8'h02);
      sleep_save_i <= 1'b1;
      for (k = 0; k < 600 && wake_o !== 1'b1; k++)
         @(negedge sys_clk_i);
      `CHK(wake_o, 1'b1)
      if (wake_o !== 1'b1)
         test_done();
      @(negedge sys_clk_i);
      `CHK(cpu_halt_o, 1'b1)
      `CHK(irq_req_o, 1'b0)
      @(posedge sys_clk_i);
      sleep_save_i <= 1'b0;
      @(posedge sys_clk_i);
      wr(8'hb8, 8'h00);
      wr(8'hb1, 8'h00);
      // switch to the oscillator pin
      wr(8'hb6, 8'h60);
      @(negedge sys_clk_i);
      `CHK({port_c_detach_o, osc_external_o, osc_run_o}, 3'b111)
      @(posedge sys_clk_i);
      bus(1'b1, 1'b0, 8'hb3, 8'h33);
      bus(1'b0, 1'b1, 8'hb6, 8'h00);
      bus(1'b0, 1'b0, 8'hb6, 8'h00);
      `CHK(q[3], 1'b1)
      wait_val(8'hb6, 8'h1f, 8'h00);
      rdc(8'hb6, 8'h60, 8'hff);
      rdc(8'hb3, 8'h33, 8'hff);
      sleep_deep_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      `CHK(osc_run_o, 1'b0)
      test_done();
   end
endmodule // async_timer_sync_and_compare_output_test

// [bench/atsc_osc_model.sv]
// crystal or external clock source at the oscillator input pin
// assumes run_i follows the block's oscillator-run output
`timescale 1ns/1ps
module atsc_osc_model
// half period a multiple of the bench clock, so edges land off its rising edge
#(parameter int HALF_NS = 50)
(
   // control
   input wire run_i,
   // pin
   output logic osc_o
);
   initial osc_o = 1'b0;
   // stands low while stopped, toggles at crystal rate otherwise
   always
   begin
      #HALF_NS;
      osc_o = run_i ? ~osc_o : 1'b0;
   end
endmodule // atsc_osc_model

// [bench/atsc_timer_asserts.sv]
// timing checks on the ports of the asynchronous timer block
// assumes clk_en_i stays high while checked
`timescale 1ns/1ps
module atsc_timer_asserts
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   // oscillator, sleep, processor side
   input wire sleep_deep_i,
   input wire osc_run_o,
   input wire osc_external_o,
   input wire port_c_detach_o,
   input wire wake_o,
   input wire cpu_halt_o,
   input wire irq_req_o
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_read_idle: assert property ($past(rst_b_i) && !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
   a_busy_set: assert property (wr_i && addr_i == 8'hb3 ##1 rd_i && addr_i == 8'hb6
      |=> rdata_o[3])
      else $error("compare busy not set after write");
   a_psr_reads_zero: assert property (rd_i && addr_i == 8'ha3 |=> rdata_o == 8'h00)
      else $error("general control read not zero");
   a_force_reads_zero: assert property (rd_i && addr_i == 8'hb1 |=> !rdata_o[7])
      else $error("force strobe read back as one");
   a_halt_len: assert property (wake_o |=> cpu_halt_o [*4] ##1 !cpu_halt_o)
      else $error("halt length after wake wrong");
   a_halt_cause: assert property ($rose(cpu_halt_o) |-> $past(wake_o))
      else $error("halt without wake");
   a_irq_after_halt: assert property (cpu_halt_o |-> !irq_req_o)
      else $error("interrupt during halt");
   a_wake_pulse: assert property (wake_o |=> !wake_o)
      else $error("wake longer than one cycle");
   a_async_detach: assert property (wr_i && addr_i == 8'hb6 && wdata_i[5]
      |-> ##[1:2] port_c_detach_o)
      else $error("pins not detached after async select");
   a_ext_select: assert property (wr_i && addr_i == 8'hb6 && wdata_i[6]
      |-> ##[1:2] osc_external_o)
      else $error("external clock select not taken");
   a_deep_stop: assert property ($past(sleep_deep_i, 2) && $past(sleep_deep_i)
      |-> !osc_run_o)
      else $error("oscillator runs in deep sleep");

   c_wake: cover property (wake_o ##1 cpu_halt_o);
   c_async: cover property ($rose(port_c_detach_o));
   c_irq: cover property ($rose(irq_req_o));
endmodule // atsc_timer_asserts

bind atsc_timer atsc_timer_asserts u_chk (.*);

// [verilog/atsc_timer.v]
// asynchronous timer core: clock select, prescaler, write hand-over,
// count read-back, wake-up sequencing and compare-A output unit
// assumes osc_in_pin_i is sampled on sys_clk_i, which runs over 4x its rate
//
// What this block does
// - count, compare and control A/B writes wait in a holding register for two source clock edges
// - five registers each own a separate holding register
// - one busy flag per held register, cleared once transferred
// - compare matches are blocked while count or compare-A writes are pending
// - switching clock source may corrupt count, compare and control
// - after wake the interrupt logic rearms only after one source clock edge
// - wake starts on the system clock cycle after the interrupt condition
// - after wake the processor halts four cycles, then takes the interrupt
// - count reads through a copy refreshed on each source clock edge
// - flags reach the processor side after one timer plus three cycles
// - compare output changes on the timer clock, not re-synchronised
// - source defaults to io clock; async select takes oscillator pin
// - external select lets an external clock drive the oscillator input
// - prescaler gives stop, undivided, /8 /32 /64 /128 /256 /1024
// - prescaler reset bit clears the prescaler phase
// - oscillator stops in deep sleep or without async select; contents lost after it
// - any compare-A mode bit overrides the port; direction still needed
// - non-pwm: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm: 10 clear/set bottom, 11 inverse, 01 toggle if high bit
// - phase correct: 10 clear up-match set down-match, 11 opposite
// - fast pwm with compare at top: ignore match, act at bottom
// - phase correct with compare at top: ignore match, act at top
// - waveform modes 0,1,2,3,5,7 decoded; 4 and 6 reserved
// - force strobe applies match action in non-pwm mode, no flag
`timescale 1ns/1ps
`include "atsc_timer_regs.vh"

module atsc_timer
(
   // clock, reset, enable
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire clk_en_i,
   // register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // oscillator and sleep
   input wire osc_in_pin_i,
   input wire sleep_save_i,
   input wire sleep_deep_i,
   output reg osc_run_o,
   output reg osc_external_o,
   output reg port_c_detach_o,
   // compare output pin
   output reg compare_a_output_o,
   output reg oca_override_o,
   // processor side
   output reg wake_o,
   output reg cpu_halt_o,
   output reg irq_req_o
);

   reg [7:0] hold_ff [0:`ATSC_NHOLD-1];
   reg [1:0] ecnt_ff [0:`ATSC_NHOLD-1];
   reg [`ATSC_NHOLD-1:0] busy_ff;
   wire [`ATSC_NHOLD-1:0] ld;
   reg [7:0] cmpa_ff, cmpb_ff, ctla_ff, cnt_ff, cnt_rd_ff, nxt_rd;
   reg [3:0] ctlb_ff;
   reg [9:0] psc_ff, mask;
   reg [2:0] sh_cmp_ff, sh_ovf_ff, halt_ff;
   reg [1:0] flag_ff, en_ff;
   reg async_ff, external_osc_clock_select_ff, osc_d_ff, down_ff, oc_ff, pend_cmp_ff, pend_ovf_ff;
   reg sleep_d_ff, asleep_ff, can_wake_ff, armed_ff, nxt_oc;

   wire osc_on = async_ff & ~sleep_deep_i;
   wire osc_rise = osc_on & osc_in_pin_i & ~osc_d_ff;
   wire src = async_ff ? osc_rise : 1'b1;
   wire [2:0] cs = ctlb_ff[2:0];
   wire [2:0] wgm = {ctlb_ff[`ATSC_WGM_HI_BIT], ctla_ff[1:0]};
   wire [1:0] com = ctla_ff[7:6];
   wire pwm_fast = (wgm == 3'd3) | (wgm == 3'd7);
   wire pwm_pc = (wgm == 3'd1) | (wgm == 3'd5);
   wire top_cmp = (wgm == 3'd2) | wgm[2];
   wire [7:0] top = top_cmp ? cmpa_ff : `ATSC_TOP_MAX;
   wire tick = src & ((psc_ff & mask) == mask) & (cs != 3'd0);
   wire at_top = cnt_ff == top;
   wire at_bot = cnt_ff == 8'h00;
   wire mtch = tick & (cnt_ff == cmpa_ff) & ~busy_ff[`ATSC_H_COUNT]
      & ~busy_ff[`ATSC_H_CMPA];
   wire top_eq = (cmpa_ff == top) & com[1];
   wire ovf_ev = tick & (pwm_pc ? (at_bot & down_ff) : (cnt_ff == `ATSC_TOP_MAX));
   wire wr_ctlb = wr_i & (addr_i == `ATSC_CTRL_B);
   wire force_a = wr_ctlb & wdata_i[`ATSC_FORCE_A_BIT] & ~pwm_fast & ~pwm_pc;
   wire wake_cond = |(flag_ff & en_ff);

   // prescaler tap selection
   always @*
   begin
      case (cs)
         3'd2: mask = 10'h007;
         3'd3: mask = 10'h01f;
         3'd4: mask = 10'h03f;
         3'd5: mask = 10'h07f;
         3'd6: mask = 10'h0ff;
         3'd7: mask = 10'h3ff;
         default: mask = 10'h000;
      endcase
   end

   // hand-over of held writes, one slot per register
   genvar i;
   generate
      for (i = 0; i < `ATSC_NHOLD; i = i + 1)
      begin : g_hold
         wire hit;
         assign hit = wr_i & (addr_i == `ATSC_CTRL_A + 8'd0 + (i == `ATSC_H_COUNT ? 8'd2 :
            i == `ATSC_H_CMPA ? 8'd3 : i == `ATSC_H_CMPB ? 8'd4 :
            i == `ATSC_H_CTLA ? 8'd0 : 8'd1));
         assign ld[i] = busy_ff[i] & src & (ecnt_ff[i] == `ATSC_XFER_EDGES - 2'd1);
         always @(posedge sys_clk_i)
         begin
            if (!rst_b_i)
            begin
               hold_ff[i] <= `ATSC_RST_VAL;
               ecnt_ff[i] <= 2'd0;
               busy_ff[i] <= 1'b0;
            end
            else if (clk_en_i)
            begin
               if (hit)
               begin
                  hold_ff[i] <= wdata_i;
                  ecnt_ff[i] <= 2'd0;
                  busy_ff[i] <= 1'b1;
               end
               else if (ld[i])
               begin
                  busy_ff[i] <= 1'b0;
                  ecnt_ff[i] <= 2'd0;
               end
               else if (busy_ff[i] & src)
               begin
                  ecnt_ff[i] <= ecnt_ff[i] + 2'd1;
               end
            end
         end
      end
   endgenerate

   // destination registers; source change does not preserve them
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         cmpa_ff <= `ATSC_RST_VAL;
         cmpb_ff <= `ATSC_RST_VAL;
         ctla_ff <= `ATSC_RST_VAL;
         ctlb_ff <= 4'h0;
      end
      else if (clk_en_i)
      begin
         if (ld[`ATSC_H_CMPA])
            cmpa_ff <= hold_ff[`ATSC_H_CMPA];
         if (ld[`ATSC_H_CMPB])
            cmpb_ff <= hold_ff[`ATSC_H_CMPB];
         if (ld[`ATSC_H_CTLA])
            ctla_ff <= {hold_ff[`ATSC_H_CTLA][7:4], 2'b00, hold_ff[`ATSC_H_CTLA][1:0]};
         if (ld[`ATSC_H_CTLB])
            ctlb_ff <= hold_ff[`ATSC_H_CTLB][3:0];
      end
   end

   // clock source select, oscillator edge, prescaler
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         async_ff <= 1'b0;
         external_osc_clock_select_ff <= 1'b0;
         osc_d_ff <= 1'b0;
         psc_ff <= 10'h000;
      end
      else if (clk_en_i)
      begin
         osc_d_ff <= osc_in_pin_i;
         if (wr_i & (addr_i == `ATSC_ASYNC_STATUS))
         begin
            async_ff <= wdata_i[`ATSC_ASYNC_BIT];
            external_osc_clock_select_ff <= wdata_i[`ATSC_EXTERNAL_OSC_CLOCK_SELECT_BIT];
         end
         if (wr_i & (addr_i == `ATSC_GEN_CTRL) & wdata_i[`ATSC_PSR_BIT])
            psc_ff <= 10'h000;
         else if (src)
            psc_ff <= psc_ff + 10'h001;
      end
   end

   // counter and read-back copy
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         cnt_ff <= `ATSC_RST_VAL;
         down_ff <= 1'b0;
         cnt_rd_ff <= `ATSC_RST_VAL;
      end
      else if (clk_en_i)
      begin
         if (ld[`ATSC_H_COUNT])
            cnt_ff <= hold_ff[`ATSC_H_COUNT];
         else if (tick & pwm_pc)
         begin
            if (!down_ff & at_top)
            begin
               down_ff <= 1'b1;
               cnt_ff <= cnt_ff - 8'd1;
            end
            else if (down_ff & at_bot)
            begin
               down_ff <= 1'b0;
               cnt_ff <= cnt_ff + 8'd1;
            end
            else
               cnt_ff <= down_ff ? cnt_ff - 8'd1 : cnt_ff + 8'd1;
         end
         else if (tick)
         begin
            down_ff <= 1'b0;
            cnt_ff <= at_top ? 8'h00 : cnt_ff + 8'd1;
         end
         if (src)
            cnt_rd_ff <= cnt_ff;
      end
   end

   // compare-A waveform decoding
   always @*
   begin
      nxt_oc = oc_ff;
      if (force_a | (mtch & ~pwm_fast & ~pwm_pc))
      begin
         case (com)
            2'b01: nxt_oc = ~oc_ff;
            2'b10: nxt_oc = 1'b0;
            2'b11: nxt_oc = 1'b1;
            default: nxt_oc = oc_ff;
         endcase
      end
      else if (pwm_fast & tick)
      begin
         if (com[1] & at_top)
            nxt_oc = ~com[0];
         else if (com[1] & mtch & ~top_eq)
            nxt_oc = com[0];
         else if ((com == 2'b01) & wgm[2] & mtch)
            nxt_oc = ~oc_ff;
      end
      else if (pwm_pc & tick)
      begin
         if (com[1] & top_eq & at_top & ~down_ff)
            nxt_oc = ~com[0];
         else if (com[1] & mtch & ~top_eq)
            nxt_oc = down_ff ? ~com[0] : com[0];
         else if ((com == 2'b01) & wgm[2] & mtch)
            nxt_oc = ~oc_ff;
      end
   end

   // output compare register follows the timer tick directly
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         oc_ff <= 1'b0;
      else if (clk_en_i)
         oc_ff <= nxt_oc;
   end

   // event flags: one timer cycle, then three system stages
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         pend_cmp_ff <= 1'b0;
         pend_ovf_ff <= 1'b0;
         sh_cmp_ff <= 3'b000;
         sh_ovf_ff <= 3'b000;
         flag_ff <= 2'b00;
         en_ff <= 2'b00;
      end
      else if (clk_en_i)
      begin
         if (tick)
         begin
            pend_cmp_ff <= mtch;
            pend_ovf_ff <= ovf_ev;
         end
         sh_cmp_ff <= {sh_cmp_ff[1:0], tick & pend_cmp_ff};
         sh_ovf_ff <= {sh_ovf_ff[1:0], tick & pend_ovf_ff};
         if (wr_i & (addr_i == `ATSC_IRQ_EN))
            en_ff <= wdata_i[1:0];
         // set wins over a same-cycle clear
         flag_ff[`ATSC_FLAG_CMPA] <= sh_cmp_ff[2] | (flag_ff[`ATSC_FLAG_CMPA]
            & ~(wr_i & (addr_i == `ATSC_FLAGS) & wdata_i[`ATSC_FLAG_CMPA]));
         flag_ff[`ATSC_FLAG_OVF] <= sh_ovf_ff[2] | (flag_ff[`ATSC_FLAG_OVF]
            & ~(wr_i & (addr_i == `ATSC_FLAGS) & wdata_i[`ATSC_FLAG_OVF]));
      end
   end

   // sleep, wake and processor halt sequencing
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         sleep_d_ff <= 1'b0;
         asleep_ff <= 1'b0;
         can_wake_ff <= 1'b0;
         armed_ff <= 1'b1;
         halt_ff <= 3'd0;
         wake_o <= 1'b0;
         cpu_halt_o <= 1'b0;
         irq_req_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         sleep_d_ff <= sleep_save_i;
         wake_o <= 1'b0;
         if (sleep_save_i & ~sleep_d_ff)
         begin
            asleep_ff <= 1'b1;
            can_wake_ff <= armed_ff;
         end
         else if (asleep_ff & can_wake_ff & wake_cond)
         begin
            asleep_ff <= 1'b0;
            armed_ff <= 1'b0;
            wake_o <= 1'b1;
            halt_ff <= `ATSC_HALT_CYCLES;
         end
         else if (!sleep_save_i)
            asleep_ff <= 1'b0;
         if (!armed_ff & src)
            armed_ff <= 1'b1;
         if (halt_ff != 3'd0)
            halt_ff <= halt_ff - 3'd1;
         cpu_halt_o <= (halt_ff != 3'd0) | wake_o;
         irq_req_o <= wake_cond & ~asleep_ff & (halt_ff == 3'd0) & ~wake_o;
      end
   end

   // register read mux
   always @*
   begin
      case (addr_i)
         `ATSC_CTRL_A: nxt_rd = ctla_ff;
         `ATSC_CTRL_B: nxt_rd = {4'h0, ctlb_ff};
         `ATSC_COUNT: nxt_rd = cnt_rd_ff;
         `ATSC_CMP_A: nxt_rd = cmpa_ff;
         `ATSC_CMP_B: nxt_rd = cmpb_ff;
         `ATSC_ASYNC_STATUS: nxt_rd = {1'b0, external_osc_clock_select_ff, async_ff, busy_ff[0], busy_ff[1],
            busy_ff[2], busy_ff[3], busy_ff[4]};
         `ATSC_FLAGS: nxt_rd = {6'h00, flag_ff};
         `ATSC_IRQ_EN: nxt_rd = {6'h00, en_ff};
         default: nxt_rd = 8'h00;
      endcase
   end

   // registered outputs
   always @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         rdata_o <= 8'h00;
         osc_run_o <= 1'b0;
         osc_external_o <= 1'b0;
         port_c_detach_o <= 1'b0;
         compare_a_output_o <= 1'b0;
         oca_override_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rdata_o <= rd_i ? nxt_rd : 8'h00;
         osc_run_o <= osc_on;
         osc_external_o <= external_osc_clock_select_ff;
         port_c_detach_o <= async_ff;
         compare_a_output_o <= nxt_oc;
         oca_override_o <= |com;
      end
   end

endmodule // atsc_timer

// [verilog/atsc_timer_regs.vh]
// register map, field positions and counts of the asynchronous timer block
// assumes an 8-bit register port and one system clock
`ifndef ATSC_TIMER_REGS_VH
`define ATSC_TIMER_REGS_VH

// register byte offsets
`define ATSC_GEN_CTRL 8'ha3
`define ATSC_CTRL_A 8'hb0
`define ATSC_CTRL_B 8'hb1
`define ATSC_COUNT 8'hb2
`define ATSC_CMP_A 8'hb3
`define ATSC_CMP_B 8'hb4
`define ATSC_ASYNC_STATUS 8'hb6
`define ATSC_FLAGS 8'hb7
`define ATSC_IRQ_EN 8'hb8

// reset value of every register
`define ATSC_RST_VAL 8'h00

// holding register indices
`define ATSC_H_COUNT 0
`define ATSC_H_CMPA 1
`define ATSC_H_CMPB 2
`define ATSC_H_CTLA 3
`define ATSC_H_CTLB 4
`define ATSC_NHOLD 5

// field positions
`define ATSC_EXTERNAL_OSC_CLOCK_SELECT_BIT 6
`define ATSC_ASYNC_BIT 5
`define ATSC_FORCE_A_BIT 7
`define ATSC_WGM_HI_BIT 3
`define ATSC_PSR_BIT 1
`define ATSC_FLAG_CMPA 1
`define ATSC_FLAG_OVF 0

// timing counts
`define ATSC_XFER_EDGES 2'h2
`define ATSC_HALT_CYCLES 3'h4
`define ATSC_TOP_MAX 8'hff

`endif
